// [rtl/bla_baseline_avg.sv]
// baseline capture, histogram, running average and peak subtraction
// assumes filter outputs and peak values are synchronous to i_clk_sys
//
// The APB interface to the registers and the register offsets were decided locally.
module bla_baseline_avg
  import bla_pkg::*;
(
  // clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_resetn,
  // apb slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [11:0]       i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // converter stream and decimated sums
  input  wire bla_adc_t          i_adc,
  output bla_dec_t               o_dec,
  // filter outputs and captured peaks
  input  wire bla_sample_t       i_energy,
  input  wire bla_sample_t       i_inter,
  input  wire bla_sample_t       i_peak,
  output bla_sample_t            o_energy
);

  // bin index of a sample under offset and shift, clamped to the table
  // the difference is one bit wider so that a far negative sample
  // cannot wrap into a high bin
  function automatic logic [HIST_AW-1:0] bla_bin(
    input logic signed [SMP_W-1:0] x,
    input logic signed [SMP_W-1:0] ofs,
    input logic        [3:0]       shf
  );
    logic signed [SMP_W:0] rel;
    logic signed [SMP_W:0] sh;
    rel = (SMP_W+1)'(x) - (SMP_W+1)'(ofs);
    sh  = rel >>> shf;
    if (sh < 0)
      bla_bin = '0;
    else if (sh > (SMP_W+1)'(HIST_N - 1))
      bla_bin = HIST_AW'(HIST_N - 1);
    else
      bla_bin = sh[HIST_AW-1:0];
  endfunction : bla_bin

  // register file
  logic              en, cut_en, clr_req;
  logic [2:0]        dec_n;
  logic [3:0]        init_log2, hist_shf;
  logic [15:0]       weight, ivl, cut_up, cut_lo;
  logic signed [15:0] bl_thr, int_thr, hist_ofs;
  // internal state
  logic              en_q, init_done, clr_busy;
  logic [HIST_AW-1:0] clr_idx, peak_bin;
  logic [CNT_W-1:0]  peak_cnt, ivl_cnt, init_cnt, n_cap, n_cut;
  logic [5:0]        dec_cnt;
  logic [DEC_W-1:0]  dec_acc;
  logic signed [ACC_W-1:0] init_sum, acc;
  logic              cap_valid;
  logic signed [SMP_W-1:0] cap_data;
  logic [CNT_W-1:0]  hist [HIST_N];
  logic [31:0]       next_prdata;
  logic              next_pslverr;

  wire logic acc_ph = i_psel & i_penable;
  wire logic wr_en  = acc_ph & i_pwrite & o_pready;
  wire logic start  = en & ~en_q;
  wire logic signed [SMP_W-1:0] avg = acc[FRAC_W+SMP_W-1:FRAC_W];

  // register writes; the wipe request clears itself one cycle later
  // a write lands only at the edge where pready is high, so it is never
  // applied twice for one transfer
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      en <= 1'b0; cut_en <= 1'b0; clr_req <= 1'b0;
      dec_n <= DEC_RST; init_log2 <= INIT_RST; hist_shf <= HSHF_RST;
      weight <= WEIGHT_RST; ivl <= IVL_RST;
      bl_thr <= THR_RST; int_thr <= THR_RST;
      cut_up <= CUT_RST; cut_lo <= CUT_RST; hist_ofs <= HOFS_RST;
    end else begin
      clr_req <= 1'b0;
      if (wr_en) begin
        unique case (i_paddr)
          REG_CTRL: begin
            en        <= i_pwdata[CTRL_EN];
            cut_en    <= i_pwdata[CTRL_CUT];
            clr_req   <= i_pwdata[CTRL_CLR];
            dec_n     <= i_pwdata[CTRL_DEC_LO +: 3];
            init_log2 <= i_pwdata[CTRL_INIT_LO +: 4];
          end
          REG_WEIGHT: weight   <= i_pwdata[15:0];
          REG_BLTHR:  bl_thr   <= i_pwdata[15:0];
          REG_INTTHR: int_thr  <= i_pwdata[15:0];
          REG_IVL:    ivl      <= i_pwdata[15:0];
          REG_CUTUP:  cut_up   <= i_pwdata[15:0];
          REG_CUTLO:  cut_lo   <= i_pwdata[15:0];
          REG_HISTCF: begin
            hist_ofs <= i_pwdata[15:0];
            hist_shf <= i_pwdata[HCF_SHIFT_LO +: 4];
          end
          default: ;
        endcase
      end
    end
  end

  // read mux; histogram bins sit in a word window, other addresses error
  // the selected word is captured at the same edge at which pready rises
  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (i_paddr >= HIST_BASE && i_paddr[1:0] == 2'b00 &&
        i_paddr < HIST_BASE + 12'(4 * HIST_N)) begin
      next_prdata = 32'(hist[i_paddr[HIST_AW+1:2]]);
    end else begin
      unique case (i_paddr)
        REG_CTRL:   next_prdata = {16'h0000, init_log2, 1'b0, dec_n,
                                   5'h00, 1'b0, cut_en, en};
        REG_WEIGHT: next_prdata = {16'h0000, weight};
        REG_BLTHR:  next_prdata = {16'h0000, bl_thr};
        REG_INTTHR: next_prdata = {16'h0000, int_thr};
        REG_IVL:    next_prdata = {16'h0000, ivl};
        REG_CUTUP:  next_prdata = {16'h0000, cut_up};
        REG_CUTLO:  next_prdata = {16'h0000, cut_lo};
        REG_HISTCF: next_prdata = {12'h000, hist_shf, hist_ofs};
        REG_STATUS: next_prdata = {30'h0000_0000, clr_busy, init_done};
        REG_AVG:    next_prdata = {{16{avg[SMP_W-1]}}, avg};
        REG_PEAK:   next_prdata = {peak_cnt, 8'h00, peak_bin};
        REG_COUNT:  next_prdata = {n_cut, n_cap};
        default:    next_pslverr = 1'b1;
      endcase
    end
  end

  // apb answer: one wait state, ready and data registered
  // ready drops after one cycle, so an access phase held too long
  // sees ready, and a new answer, again every second cycle
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= acc_ph & ~o_pready;
      o_prdata  <= (acc_ph & ~o_pready & ~i_pwrite) ? next_prdata : o_prdata;
      o_pslverr <= acc_ph & ~o_pready & next_pslverr;
    end
  end

  // decimator: sum each group of 2**N converter samples into one output
  // a change of N in mid-group only alters the length of that one group
  // the six-bit group counter covers N up to 6
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      dec_cnt <= 6'h00;
      dec_acc <= '0;
      o_dec   <= '0;
    end else begin
      o_dec.valid <= 1'b0;
      if (i_adc.valid) begin
        if (dec_cnt == 6'((7'h01 << dec_n) - 7'h01)) begin
          o_dec.valid <= 1'b1;
          o_dec.sum   <= dec_acc + DEC_W'(i_adc.data);
          dec_acc     <= '0;
          dec_cnt     <= 6'h00;
        end else begin
          dec_acc <= dec_acc + DEC_W'(i_adc.data);
          dec_cnt <= dec_cnt + 6'h01;
        end
      end
    end
  end

  // baseline source and threshold depend on decimation
  // strictly below the threshold counts as baseline; equal is a step
  // the interval gate is bypassed until the initial batch is in
  wire logic use_int = (dec_n != 3'h0);
  wire bla_sample_t src = use_int ? i_inter : i_energy;
  wire logic signed [SMP_W-1:0] thr = use_int ? int_thr : bl_thr;
  wire logic below = src.valid & (src.data < thr);
  wire logic due   = ~init_done | (ivl_cnt >= ivl);
  wire logic take  = en & ~clr_busy & below & due;

  // capture register and interval counter in decimated samples
  // the capture stage breaks the path from the source mux into the
  // histogram read-modify-write
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cap_valid <= 1'b0;
      cap_data  <= '0;
      ivl_cnt   <= '0;
      en_q      <= 1'b0;
    end else begin
      en_q      <= en;
      cap_valid <= take;
      if (take)
        cap_data <= src.data;
      if (start || take)
        ivl_cnt <= '0;
      else if (src.valid && ivl_cnt != {CNT_W{1'b1}})
        ivl_cnt <= ivl_cnt + 1'b1;
    end
  end

  // histogram increment and wipe sweep
  // the table has no reset; the sweep after reset clears it instead
  // bins saturate so a long run cannot wrap a busy bin back to zero
  wire logic [HIST_AW-1:0] cap_bin = bla_bin(cap_data, hist_ofs, hist_shf);
  wire logic [CNT_W-1:0] cur_cnt = hist[cap_bin];
  wire logic [CNT_W-1:0] new_cnt =
    (cur_cnt == {CNT_W{1'b1}}) ? cur_cnt : cur_cnt + 1'b1;
  always_ff @(posedge i_clk_sys) begin
    if (clr_busy)
      hist[clr_idx] <= '0;
    else if (cap_valid)
      hist[cap_bin] <= new_cnt;
  end

  // sweep control, peak bin tracking and capture counters
  // a wipe request wins over a capture that lands in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      clr_busy <= 1'b1;
      clr_idx  <= '0;
      peak_bin <= '0;
      peak_cnt <= '0;
      n_cap    <= '0;
    end else if (clr_req) begin
      clr_busy <= 1'b1;
      clr_idx  <= '0;
      peak_bin <= '0;
      peak_cnt <= '0;
      n_cap    <= '0;
    end else if (clr_busy) begin
      clr_idx  <= clr_idx + 1'b1;
      clr_busy <= (clr_idx != HIST_AW'(HIST_N - 1));
    end else if (cap_valid) begin
      n_cap <= (n_cap == {CNT_W{1'b1}}) ? n_cap : n_cap + 1'b1;
      if (new_cnt > peak_cnt) begin
        peak_cnt <= new_cnt;
        peak_bin <= cap_bin;
      end
    end
  end

  // cut window around the value at the histogram peak
  // the limits are unsigned widths, made signed so that negative
  // baseline values still compare as numbers, not as raw bit patterns
  wire logic signed [SMP_W+2:0] e0 = (SMP_W+3)'(hist_ofs) +
    (SMP_W+3)'({1'b0, peak_bin} << hist_shf);
  wire logic signed [SMP_W+2:0] capx = (SMP_W+3)'(cap_data);
  wire logic cut_hit = cut_en & (peak_cnt != '0) &
    ((capx > e0 + $signed((SMP_W+3)'({1'b0, cut_up}))) |
     (capx < e0 - $signed((SMP_W+3)'({1'b0, cut_lo}))));

  // running average: initial batch mean, then exponential updates
  // cutting is held off while the batch forms, while the histogram
  // peak is still being built from the batch samples themselves
  // the product is two bits wider than the accumulator so that the
  // signed step cannot overflow before it is added
  wire logic signed [SMP_W:0] diff = (SMP_W+1)'(cap_data) - (SMP_W+1)'(avg);
  wire logic signed [ACC_W+1:0] step =
    (ACC_W+2)'($signed({1'b0, weight})) * (ACC_W+2)'(diff);
  wire logic signed [ACC_W-1:0] init_next = init_sum + ACC_W'(cap_data);
  wire logic last_init =
    (init_cnt == CNT_W'((17'h00001 << init_log2) - 17'h00001));
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      acc       <= '0;
      init_sum  <= '0;
      init_cnt  <= '0;
      init_done <= 1'b0;
      n_cut     <= '0;
    end else if (start) begin
      init_sum  <= '0;
      init_cnt  <= '0;
      init_done <= 1'b0;
    end else if (cap_valid && !init_done) begin
      init_sum <= init_next;
      init_cnt <= init_cnt + 1'b1;
      if (last_init) begin
        acc       <= (init_next >>> init_log2) <<< FRAC_W;
        init_done <= 1'b1;
      end
    end else if (cap_valid && cut_hit) begin
      n_cut <= (n_cut == {CNT_W{1'b1}}) ? n_cut : n_cut + 1'b1;
    end else if (cap_valid) begin
      acc <= ACC_W'((ACC_W+2)'(acc) + step);
    end
  end

  // energy output: peak minus current baseline average
  // data wraps in 16 bits and holds its last value between strobes
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_energy <= '0;
    end else begin
      o_energy.valid <= i_peak.valid;
      if (i_peak.valid)
        o_energy.data <= i_peak.data - avg;
    end
  end

endmodule : bla_baseline_avg

// [rtl/bla_pkg.sv]
// constants, register map and carriers for the baseline averaging stage
// assumes one system clock; filter data arrives as per-sample valid strobes
package bla_pkg;

  // data widths
  localparam int SMP_W   = 16;
  localparam int ADC_W   = 14;
  localparam int DEC_W   = 20;
  localparam int ACC_W   = 32;
  localparam int HIST_AW = 8;
  localparam int HIST_N  = 256;
  localparam int CNT_W   = 16;
  localparam int FRAC_W  = 15;          // weight full scale is 2**15 = 32768

  // register byte offsets
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_WEIGHT = 12'h004;
  localparam logic [11:0] REG_BLTHR  = 12'h008;
  localparam logic [11:0] REG_INTTHR = 12'h00C;
  localparam logic [11:0] REG_IVL    = 12'h010;
  localparam logic [11:0] REG_CUTUP  = 12'h014;
  localparam logic [11:0] REG_CUTLO  = 12'h018;
  localparam logic [11:0] REG_HISTCF = 12'h01C;
  localparam logic [11:0] REG_STATUS = 12'h020;
  localparam logic [11:0] REG_AVG    = 12'h024;
  localparam logic [11:0] REG_PEAK   = 12'h028;
  localparam logic [11:0] REG_COUNT  = 12'h02C;
  localparam logic [11:0] HIST_BASE  = 12'h400;

  // control field positions
  localparam int CTRL_EN      = 0;
  localparam int CTRL_CUT     = 1;
  localparam int CTRL_CLR     = 2;    // self-clearing histogram wipe
  localparam int CTRL_DEC_LO  = 8;    // decimation N, 3 bits
  localparam int CTRL_INIT_LO = 12;   // log2 of initial batch, 4 bits
  localparam int HCF_SHIFT_LO = 16;   // histogram bin shift, 4 bits

  // values after reset
  localparam logic [15:0] WEIGHT_RST = 16'h0200;
  localparam logic [15:0] THR_RST    = 16'h0100;
  localparam logic [15:0] IVL_RST    = 16'h0010;
  localparam logic [15:0] CUT_RST    = 16'h0040;
  localparam logic [3:0]  INIT_RST   = 4'h6;
  localparam logic [2:0]  DEC_RST    = 3'h0;
  localparam logic [15:0] HOFS_RST   = 16'hFF80;
  localparam logic [3:0]  HSHF_RST   = 4'h0;

  // one filter sample or peak value with its strobe
  typedef struct packed {
    logic                    valid;
    logic signed [SMP_W-1:0] data;
  } bla_sample_t;

  // one converter sample
  typedef struct packed {
    logic             valid;
    logic [ADC_W-1:0] data;
  } bla_adc_t;

  // one decimated sum
  typedef struct packed {
    logic             valid;
    logic [DEC_W-1:0] sum;
  } bla_dec_t;

endpackage : bla_pkg

// [tb/bla_assertions.sv]
// port checker for the baseline averaging stage
// assumes it is bound to bla_baseline_avg and sees only its ports
module bla_checker
  import bla_pkg::*;
(
  // clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_resetn,
  // apb and streams
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire bla_adc_t    i_adc,
  input wire bla_dec_t    o_dec,
  input wire bla_sample_t i_peak,
  input wire bla_sample_t o_energy
);
  timeunit 1ns;
  timeprecision 1ps;
  // all checks share the system clock and reset
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // apb answer timing
  ready_wait_a: assert property (
    i_psel && i_penable && !o_pready |=> o_pready) else $error("late ready");
  ready_cause_a: assert property (
    o_pready |-> $past(i_psel && i_penable)) else $error("stray ready");
  ready_pulse_a: assert property (
    o_pready |=> !o_pready) else $error("ready held");
  error_ready_a: assert property (
    o_pslverr |-> o_pready) else $error("error without ready");
  // stream answer timing and quiet outputs after reset
  dec_cause_a: assert property (
    o_dec.valid |-> $past(i_adc.valid)) else $error("stray sum");
  peak_answer_a: assert property (
    i_peak.valid |=> o_energy.valid) else $error("missing energy");
  energy_cause_a: assert property (
    o_energy.valid |-> $past(i_peak.valid)) else $error("stray energy");
  reset_quiet_a: assert property (
    $rose(i_resetn) |-> !o_pready && !o_dec.valid && !o_energy.valid)
    else $error("output active after reset");
endmodule : bla_checker

bind bla_baseline_avg bla_checker bla_checker_inst (
  .i_clk_sys, .i_resetn, .i_psel, .i_penable, .o_pready, .o_pslverr,
  .i_adc, .o_dec, .i_peak, .o_energy);

// [tb/bla_filter_model.sv]
// far side model: converter, filter and peak capture strobes
// assumes callers of put start right after a rising clock edge
module bla_filter_model
  import bla_pkg::*;
(
  // clock
  input  wire logic   i_clk_sys,
  // streams toward the block
  output bla_adc_t    o_adc,
  output bla_sample_t o_energy,
  output bla_sample_t o_inter,
  output bla_sample_t o_peak
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet streams at time zero
  initial begin
    o_adc = '0;
    o_energy = '0;
    o_inter = '0;
    o_peak = '0;
  end
  // one strobe on stream k: 0 adc, 1 energy, 2 inter, 3 peak
  task automatic put(input int k, input logic signed [15:0] d);
    case (k)
      0: o_adc <= {1'b1, d[13:0]};
      1: o_energy <= {1'b1, d};
      2: o_inter <= {1'b1, d};
      default: o_peak <= {1'b1, d};
    endcase
    @(posedge i_clk_sys);
    // idle data toggles so a stale value is never mistaken for a sample
    o_adc <= {1'b0, ~o_adc.data};
    o_energy <= {1'b0, ~o_energy.data};
    o_inter <= {1'b0, ~o_inter.data};
    o_peak <= {1'b0, ~o_peak.data};
    @(posedge i_clk_sys);
  endtask : put
endmodule : bla_filter_model

// [tb/tb_bla_baseline_avg.sv]
// bench for the baseline averaging stage: apb access and stream tests
// assumes the filter model drives every stream input of the block
module tb_bla_baseline_avg
  import bla_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and apb master
  logic        clk_sys = 1'b0;
  logic        resetn  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = '0;
  logic [31:0] pwdata  = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rdat;
  logic        rerr;
  bla_adc_t    adc;
  bla_dec_t    dec;
  bla_sample_t energy;
  bla_sample_t inter;
  bla_sample_t peak;
  bla_sample_t eout;
  int          failures = 0;
  int          num_checks = 0;

  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;

  bla_baseline_avg bla_baseline_avg_inst (
    .i_clk_sys(clk_sys), .i_resetn(resetn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_adc(adc), .o_dec(dec), .i_energy(energy),
    .i_inter(inter), .i_peak(peak), .o_energy(eout));

  bla_filter_model fm (
    .i_clk_sys(clk_sys), .o_adc(adc), .o_energy(energy),
    .o_inter(inter), .o_peak(peak));

  // value comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, waits for pready; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(rdat, e);
    chk({31'h0, rerr}, 32'h0);
  endtask : rd

  // poll status until the histogram wipe sweep has ended
  task automatic wait_wipe();
    rdat = 32'h2;
    while (rdat[1]) apb(1'b0, REG_STATUS, '0);
  endtask : wait_wipe

  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  // watchdog against a hung handshake
  initial begin
    #40000;
    failures++;
    complete_run();
  end

  // test sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    wait_wipe();
    rd(REG_STATUS, 32'h0);
    rd(REG_WEIGHT, 32'h200);
    rd(REG_IVL, 32'h10);
    rd(REG_BLTHR, 32'h100);
    apb(1'b0, 12'h030, '0);
    chk({31'h0, rerr}, 32'h1);
    $display("test registers done");
    fm.put(0, 16'sh7);
    chk({dec.valid, 11'h0, dec.sum}, {1'b1, 31'h7});
    apb(1'b1, REG_CTRL, 32'h1001);
    fm.put(1, 16'sh300);
    fm.put(1, 16'sd10);
    fm.put(1, 16'sd20);
    repeat (2) @(posedge clk_sys);
    rd(REG_AVG, 32'd15);
    rd(REG_COUNT, 32'd2);
    rd(REG_STATUS, 32'h1);
    rd(12'h628, 32'h1);
    rd(12'h650, 32'h1);
    fm.put(3, 16'sd100);
    chk({eout.valid, 15'h0, eout.data}, {16'h8000, 16'd85});
    $display("test initial batch done");
    apb(1'b1, REG_IVL, '0);
    apb(1'b1, REG_WEIGHT, 32'h4000);
    fm.put(1, 16'sd35);
    repeat (2) @(posedge clk_sys);
    rd(REG_AVG, 32'd25);
    fm.put(3, 16'sd100);
    chk({eout.valid, 15'h0, eout.data}, {16'h8000, 16'd75});
    $display("test running average done");
    apb(1'b1, REG_CTRL, 32'h1201);
    for (int i = 1; i <= 4; i++) fm.put(0, 16'(i));
    chk({dec.valid, 11'h0, dec.sum}, {1'b1, 31'hA});
    fm.put(1, 16'sd25);
    fm.put(2, 16'sd25);
    repeat (2) @(posedge clk_sys);
    rd(REG_COUNT, 32'd4);
    $display("test decimation done");
    apb(1'b1, REG_CUTUP, 32'd5);
    apb(1'b1, REG_CUTLO, 32'd5);
    apb(1'b1, REG_CTRL, 32'h1203);
    fm.put(2, 16'sd40);
    fm.put(2, 16'sd3);
    fm.put(2, 16'sd12);
    repeat (2) @(posedge clk_sys);
    rd(REG_COUNT, 32'h0002_0007);
    rd(REG_AVG, 32'd18);
    rd(REG_PEAK, 32'h0001_008A);
    rd(12'h6A0, 32'h1);
    $display("test cut window done");
    apb(1'b1, REG_CTRL, 32'h1207);
    wait_wipe();
    rd(12'h628, 32'h0);
    rd(REG_PEAK, 32'h0);
    rd(REG_COUNT, 32'h0002_0000);
    $display("test histogram wipe done");
    complete_run();
  end
endmodule : tb_bla_baseline_avg
